//--- sysctl_map.vh
`ifndef SYSCTL_MAP_VH
`define SYSCTL_MAP_VH
`define OFS_BOOT 12'h000
`define OFS_RSTC 12'h004
`define OFS_LPWR 12'h008
`define OFS_CLKC 12'h00C
`define OFS_DPIN 12'h014
`define OFS_DHLT 12'h01C
`define OFS_WRISE 12'h020
`define OFS_WFALL 12'h024
`define OFS_WPEND 12'h028
`define OFS_PDIV 12'h038
`define OFS_SRST 12'h040
`define OFS_FRST 12'h050
`define OFS_SGATE 12'h060
`define OFS_FGATE 12'h070
`define OFS_DFRZ 12'h080
`define OFS_ID 12'h100
`define BIT_FLAG_HI 31
`define BIT_FLAG_LO 25
`define BIT_FLAG_CLR 24
`define BIT_EXT_EN 1
`define BIT_SW_RST 0
`define BIT_PLL_RDY 6
`define BIT_PLL_ON 5
`define BIT_OSC_RDY 4
`define BIT_OSC_BYP 3
`define BIT_OSC_EN 2
`define BIT_RTC_FRZ 4
`define BIT_IWD_FRZ 3
`define BOOT_LATCH_EDGE 3'h4
`define LP_SLEEP 2'h0
`define LP_STOP 2'h1
`define LP_STANDBY 2'h3
`define FREEZE_CAPABLE 29'h041FC002
`define SW_RST_CYCLES 4'hF
`endif

//--- system_control_registers.v
`timescale 1ns/100ps
`include "sysctl_map.vh"
module system_control_registers #(
	parameter SLOW_N = 29,
	parameter FAST_N = 4,
	parameter [31:0] CHIP_ID = 32'h0A5A0001
) (
	input wire clk_sys,
	input wire rst_n,
	input wire clk_en,
	input wire por_event,
	input wire [4:0] reset_source,
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [31:0] reg_rdata,
	input wire boot_pin_a,
	input wire boot_pin_b,
	input wire extlogic_reset_req,
	output wire system_reset_req,
	input wire wfi_entered,
	output wire enter_sleep,
	output wire enter_stop,
	output wire enter_standby,
	output wire stop_wakeup,
	input wire pll_ready,
	input wire ext_osc_ready,
	output wire pll_on,
	output wire ext_osc_enable,
	output wire ext_osc_bypass,
	output reg flash_clk_tick,
	output reg periph_bus_tick,
	output wire [4:0] jtag_pin_release,
	input wire debug_halted,
	output wire rtc_debug_freeze,
	output wire indep_watchdog_debug_freeze,
	input wire [7:0] ext_irq_lines,
	input wire rtc_alarm,
	output wire [SLOW_N-1:0] slow_block_reset,
	output wire [FAST_N-1:0] fast_block_reset,
	output wire [SLOW_N-1:0] slow_block_clk_en,
	output wire [FAST_N-1:0] fast_block_clk_en
);
	// The flags live in a domain that por_event alone resets, setting the POR flag, so that ordinary
	// system resets (rst_n) leave them standing.
	reg [6:0] reset_flags;
	reg [2:0] boot_cnt;
	reg [1:0] boot_mode;
	reg ext_en;
	reg [3:0] sw_rst_cnt;
	reg [1:0] lp_sel;
	reg [3:0] div_hi;
	reg [3:0] div_lo;
	reg pll_en;
	reg osc_en;
	reg osc_byp;
	reg [4:0] pin_rel;
	reg rtc_frz;
	reg iwd_frz;
	reg [8:0] rise_en;
	reg [8:0] fall_en;
	reg [8:0] pending;
	reg [3:0] pdiv;
	reg [3:0] flash_cnt;
	reg [3:0] pbus_cnt;
	reg [SLOW_N-1:0] slow_rst;
	reg [FAST_N-1:0] fast_rst;
	reg [SLOW_N-1:0] slow_gate;
	reg [FAST_N-1:0] fast_gate;
	reg [SLOW_N-1:0] dbg_frz;
	reg [8:0] wake_s1;
	reg [8:0] wake_s2;
	reg [8:0] wake_s3;
	reg [8:0] wake_prev;
	reg [2:0] ext_sync;
	reg [2:0] pll_sync;
	reg [2:0] osc_sync;
	reg ext_req_q;
	reg pll_rdy_q;
	reg osc_rdy_q;
	wire wr_ok;
	wire [8:0] wake_in;
	wire [8:0] wake_q;
	wire [8:0] rise_ev;
	wire [8:0] fall_ev;
	wire [8:0] wake_ev;
	wire clr_flags;
	wire sw_rst_pulse;
	wire ext_rst_take;
	wire [SLOW_N-1:0] frz_mask;
	wire [6:0] flag_set;
	wire [31:0] slow_frz_cap;
	reg [1:0] por_hold;
	wire wr_rstc;
	wire wr_lpwr;
	wire wr_clkc;
	wire wr_dpin;
	wire wr_dhlt;
	wire wr_wrise;
	wire wr_wfall;
	wire wr_wpend;
	wire wr_pdiv;
	wire wr_srst;
	wire wr_frst;
	wire wr_sgate;
	wire wr_fgate;
	wire wr_dfrz;

	assign wr_ok = clk_en & reg_write;
	// One strobe per writable register keeps the address decode in one place.
	assign wr_rstc = wr_ok && reg_addr == `OFS_RSTC;
	assign wr_lpwr = wr_ok && reg_addr == `OFS_LPWR;
	assign wr_clkc = wr_ok && reg_addr == `OFS_CLKC;
	assign wr_dpin = wr_ok && reg_addr == `OFS_DPIN;
	assign wr_dhlt = wr_ok && reg_addr == `OFS_DHLT;
	assign wr_wrise = wr_ok && reg_addr == `OFS_WRISE;
	assign wr_wfall = wr_ok && reg_addr == `OFS_WFALL;
	assign wr_wpend = wr_ok && reg_addr == `OFS_WPEND;
	assign wr_pdiv = wr_ok && reg_addr == `OFS_PDIV;
	assign wr_srst = wr_ok && reg_addr == `OFS_SRST;
	assign wr_frst = wr_ok && reg_addr == `OFS_FRST;
	assign wr_sgate = wr_ok && reg_addr == `OFS_SGATE;
	assign wr_fgate = wr_ok && reg_addr == `OFS_FGATE;
	assign wr_dfrz = wr_ok && reg_addr == `OFS_DFRZ;
	assign wake_in = {rtc_alarm, ext_irq_lines};
	assign clr_flags = wr_rstc && reg_wdata[`BIT_FLAG_CLR];
	assign sw_rst_pulse = wr_rstc && reg_wdata[`BIT_SW_RST];
	assign ext_rst_take = ext_req_q & ext_en;
	assign system_reset_req = (sw_rst_cnt != 4'h0) | ext_rst_take;
	// Flag order: lowpower, watchdog, indep watchdog, software, POR, pin, external.
	assign flag_set = {reset_source[4:2], sw_rst_pulse, 1'b0, reset_source[1], ext_rst_take};

	// Power-on reset is taken at once but let go two edges later, so that its
	// release can never land close to a clock edge at the flag flops.
	always @(posedge clk_sys or posedge por_event) begin
		if (por_event) begin
			por_hold <= 2'h3;
		end else if (clk_en) begin
			por_hold <= {por_hold[0], 1'b0};
		end
	end

	// Clear is by the clear-all bit only; a new cause in the same cycle wins.
	always @(posedge clk_sys or posedge por_event) begin
		if (por_event) begin
			reset_flags <= 7'h04;
		end else if (clk_en) begin
			if (por_hold[1]) begin
				reset_flags <= 7'h04;
			end else begin
				reset_flags <= (clr_flags ? 7'h00 : reset_flags) | flag_set;
			end
		end
	end

	// The pin synchronisers serve the wake, reset-request and ready inputs; the boot pins below are sampled without them.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wake_s1 <= 9'h000;
			wake_s2 <= 9'h000;
			wake_s3 <= 9'h000;
			wake_prev <= 9'h000;
			ext_sync <= 3'h0;
			pll_sync <= 3'h0;
			osc_sync <= 3'h0;
			ext_req_q <= 1'b0;
			pll_rdy_q <= 1'b0;
			osc_rdy_q <= 1'b0;
		end else if (clk_en) begin
			wake_s1 <= wake_in;
			wake_s2 <= wake_s1;
			wake_s3 <= wake_s2;
			wake_prev <= wake_q;
			ext_sync <= {ext_sync[1:0], extlogic_reset_req};
			pll_sync <= {pll_sync[1:0], pll_ready};
			osc_sync <= {osc_sync[1:0], ext_osc_ready};
			if (ext_sync[2] == ext_sync[1]) begin
				ext_req_q <= ext_sync[1];
			end
			if (pll_sync[2] == pll_sync[1]) begin
				pll_rdy_q <= pll_sync[1];
			end
			if (osc_sync[2] == osc_sync[1]) begin
				osc_rdy_q <= osc_sync[1];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < 9; g = g + 1) begin : wake_bit
			assign wake_q[g] = (wake_s2[g] == wake_s3[g]) ? wake_s2[g] : wake_prev[g];
		end
	endgenerate

	assign rise_ev = wake_q & ~wake_prev & rise_en;
	assign fall_ev = ~wake_q & wake_prev & fall_en;
	assign wake_ev = rise_ev | fall_ev;
	assign stop_wakeup = |wake_ev;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			boot_cnt <= 3'h0;
			boot_mode <= 2'h0;
		end else if (clk_en && boot_cnt != `BOOT_LATCH_EDGE) begin
			boot_cnt <= boot_cnt + 3'h1;
			if (boot_cnt == `BOOT_LATCH_EDGE - 3'h1) begin
				boot_mode <= {boot_pin_b, boot_pin_a};
			end
		end
	end

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ext_en <= 1'b0;
			sw_rst_cnt <= 4'h0;
			lp_sel <= `LP_SLEEP;
			div_hi <= 4'h0;
			div_lo <= 4'h0;
			pll_en <= 1'b0;
			osc_en <= 1'b0;
			osc_byp <= 1'b0;
			pin_rel <= 5'h00;
			rtc_frz <= 1'b0;
			iwd_frz <= 1'b0;
			rise_en <= 9'h000;
			fall_en <= 9'h000;
			pending <= 9'h000;
			pdiv <= 4'h0;
			slow_rst <= {SLOW_N{1'b0}};
			fast_rst <= {FAST_N{1'b0}};
			slow_gate <= {SLOW_N{1'b0}};
			fast_gate <= {FAST_N{1'b0}};
			dbg_frz <= {SLOW_N{1'b0}};
		end else if (clk_en) begin
			if (sw_rst_pulse) begin
				sw_rst_cnt <= `SW_RST_CYCLES;
			end else if (sw_rst_cnt != 4'h0) begin
				sw_rst_cnt <= sw_rst_cnt - 4'h1;
			end
			// Writing ones to the pending register clears those bits; events win.
			if (wr_wpend) begin
				pending <= (pending & ~reg_wdata[8:0]) | wake_ev;
			end else begin
				pending <= pending | wake_ev;
			end
			if (wr_rstc) begin
				ext_en <= reg_wdata[`BIT_EXT_EN];
			end
			if (wr_lpwr) begin
				lp_sel <= reg_wdata[1:0];
			end
			if (wr_clkc) begin
				div_hi <= reg_wdata[15:12];
				div_lo <= reg_wdata[11:8];
				pll_en <= reg_wdata[`BIT_PLL_ON];
				osc_byp <= reg_wdata[`BIT_OSC_BYP];
				osc_en <= reg_wdata[`BIT_OSC_EN];
			end
			if (wr_dpin) begin
				pin_rel <= reg_wdata[4:0];
			end
			if (wr_dhlt) begin
				rtc_frz <= reg_wdata[`BIT_RTC_FRZ];
				iwd_frz <= reg_wdata[`BIT_IWD_FRZ];
			end
			if (wr_wrise) begin
				rise_en <= reg_wdata[8:0];
			end
			if (wr_wfall) begin
				fall_en <= reg_wdata[8:0];
			end
			if (wr_pdiv) begin
				pdiv <= reg_wdata[3:0];
			end
			if (wr_srst) begin
				slow_rst <= reg_wdata[SLOW_N-1:0];
			end
			if (wr_frst) begin
				fast_rst <= reg_wdata[FAST_N-1:0];
			end
			if (wr_sgate) begin
				slow_gate <= reg_wdata[SLOW_N-1:0];
			end
			if (wr_fgate) begin
				fast_gate <= reg_wdata[FAST_N-1:0];
			end
			if (wr_dfrz) begin
				dbg_frz <= reg_wdata[SLOW_N-1:0] & frz_mask;
			end
		end
	end

	assign slow_frz_cap = {3'h0, `FREEZE_CAPABLE};
	assign frz_mask = slow_frz_cap[SLOW_N-1:0];

	// Clock dividers: one-cycle ticks every (field + 1) cycles.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			flash_cnt <= 4'h0;
			pbus_cnt <= 4'h0;
			flash_clk_tick <= 1'b0;
			periph_bus_tick <= 1'b0;
		end else if (clk_en) begin
			flash_clk_tick <= flash_cnt == 4'h0;
			flash_cnt <= (flash_cnt >= div_hi) ? 4'h0 : flash_cnt + 4'h1;
			periph_bus_tick <= pbus_cnt == 4'h0;
			pbus_cnt <= (pbus_cnt >= pdiv) ? 4'h0 : pbus_cnt + 4'h1;
		end
	end

	assign enter_sleep = wfi_entered && lp_sel == `LP_SLEEP;
	assign enter_stop = wfi_entered && lp_sel == `LP_STOP;
	assign enter_standby = wfi_entered && lp_sel == `LP_STANDBY;
	assign pll_on = pll_en;
	assign ext_osc_enable = osc_en;
	assign ext_osc_bypass = osc_byp;
	assign jtag_pin_release = pin_rel;
	assign rtc_debug_freeze = debug_halted & rtc_frz;
	assign indep_watchdog_debug_freeze = debug_halted & iwd_frz;
	assign slow_block_reset = slow_rst;
	assign fast_block_reset = fast_rst;
	// A block is clocked when gated on, unless debug freezes it. Only the gate
	// and freeze bits are stored, not the enable, so a freeze follows the halt input in the same cycle.
	generate
		for (g = 0; g < SLOW_N; g = g + 1) begin : slow_clk_bit
			assign slow_block_clk_en[g] = slow_gate[g] & ~(debug_halted & dbg_frz[g]);
		end
	endgenerate
	assign fast_block_clk_en = fast_gate;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (clk_en) begin
			reg_rdata <= 32'h00000000;
			if (reg_read) begin
				case (reg_addr)
				`OFS_BOOT: reg_rdata[1:0] <= boot_mode;
				`OFS_RSTC: begin
					reg_rdata[`BIT_FLAG_HI:`BIT_FLAG_LO] <= reset_flags;
					reg_rdata[`BIT_EXT_EN] <= ext_en;
				end
				`OFS_LPWR: reg_rdata[1:0] <= lp_sel;
				`OFS_CLKC: begin
					reg_rdata[15:8] <= {div_hi, div_lo};
					reg_rdata[`BIT_PLL_RDY] <= pll_rdy_q;
					reg_rdata[`BIT_PLL_ON] <= pll_en;
					reg_rdata[`BIT_OSC_RDY] <= osc_rdy_q;
					reg_rdata[`BIT_OSC_BYP] <= osc_byp;
					reg_rdata[`BIT_OSC_EN] <= osc_en;
				end
				`OFS_DPIN: reg_rdata[4:0] <= pin_rel;
				`OFS_DHLT: begin
					reg_rdata[`BIT_RTC_FRZ] <= rtc_frz;
					reg_rdata[`BIT_IWD_FRZ] <= iwd_frz;
				end
				`OFS_WRISE: reg_rdata[8:0] <= rise_en;
				`OFS_WFALL: reg_rdata[8:0] <= fall_en;
				`OFS_WPEND: reg_rdata[8:0] <= pending;
				`OFS_PDIV: reg_rdata[3:0] <= pdiv;
				`OFS_SRST: reg_rdata[SLOW_N-1:0] <= slow_rst;
				`OFS_FRST: reg_rdata[FAST_N-1:0] <= fast_rst;
				`OFS_SGATE: reg_rdata[SLOW_N-1:0] <= slow_gate;
				`OFS_FGATE: reg_rdata[FAST_N-1:0] <= fast_gate;
				`OFS_DFRZ: reg_rdata[SLOW_N-1:0] <= dbg_frz;
				`OFS_ID: reg_rdata <= CHIP_ID;
				default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

//--- sysctl_monitor.sv
`timescale 1ns/100ps
module sysctl_monitor #(
	parameter FAST_N = 4,
	parameter [31:0] CHIP_ID = 32'h0A5A0001
) (
	input wire clk_sys,
	input wire rst_n,
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [31:0] reg_rdata,
	input wire system_reset_req,
	input wire wfi_entered,
	input wire enter_sleep,
	input wire enter_stop,
	input wire enter_standby,
	input wire pll_on,
	input wire [4:0] jtag_pin_release,
	input wire debug_halted,
	input wire rtc_debug_freeze,
	input wire indep_watchdog_debug_freeze,
	input wire [FAST_N-1:0] fast_block_reset
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence swrst_write;
		reg_write && reg_addr == 12'h004 && reg_wdata[0];
	endsequence
	// Only the first eight cycles are held here; the bench counts the full length.
	sequence swrst_hold;
		system_reset_req [*8];
	endsequence
	swrst_pulse_a: assert property (swrst_write |=> swrst_hold)
		else $error("software reset pulse too short");
	rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	id_read_a: assert property (reg_read && reg_addr == 12'h100 |=> reg_rdata == CHIP_ID)
		else $error("identity read wrong");
	lp_onehot_a: assert property ($onehot0({enter_sleep, enter_stop, enter_standby}))
		else $error("more than one low power state");
	lp_wfi_a: assert property (enter_sleep || enter_stop || enter_standby |-> wfi_entered)
		else $error("low power entry without wfi");
	freeze_halt_a: assert property (!debug_halted |->
		!rtc_debug_freeze && !indep_watchdog_debug_freeze)
		else $error("freeze outside debug halt");
	pll_write_a: assert property (rst_n && $changed(pll_on) |->
		$past(reg_write) && $past(reg_addr) == 12'h00C)
		else $error("pll enable moved without write");
	jtag_write_a: assert property (rst_n && $changed(jtag_pin_release) |->
		$past(reg_write) && $past(reg_addr) == 12'h014)
		else $error("pin release moved without write");
	fastrst_write_a: assert property (rst_n && $changed(fast_block_reset) |->
		$past(reg_write) && $past(reg_addr) == 12'h050)
		else $error("fast reset moved without write");
endmodule
bind system_control_registers sysctl_monitor #(.FAST_N(FAST_N), .CHIP_ID(CHIP_ID)) u_mon (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.system_reset_req(system_reset_req),
	.wfi_entered(wfi_entered),
	.enter_sleep(enter_sleep),
	.enter_stop(enter_stop),
	.enter_standby(enter_standby),
	.pll_on(pll_on),
	.jtag_pin_release(jtag_pin_release),
	.debug_halted(debug_halted),
	.rtc_debug_freeze(rtc_debug_freeze),
	.indep_watchdog_debug_freeze(indep_watchdog_debug_freeze),
	.fast_block_reset(fast_block_reset)
);

//--- testbench.sv
`timescale 1ns/100ps
module testbench;
	// Arbitrary identity value.
	localparam [31:0] ID = 32'h13579BDF;
	logic clk_sys = 0, rst_n = 0, clk_en = 1, por_event = 0, reg_write = 0, reg_read = 0;
	logic boot_pin_a = 0, boot_pin_b = 1, extlogic_reset_req = 0, wfi_entered = 0;
	logic pll_ready = 1, ext_osc_ready = 0, debug_halted = 0, rtc_alarm = 0;
	logic [4:0] reset_source = 0;
	logic [11:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, d;
	logic [7:0] ext_irq_lines = 0;
	wire [31:0] reg_rdata;
	wire system_reset_req, enter_sleep, enter_stop, enter_standby, stop_wakeup, pll_on;
	wire ext_osc_enable, ext_osc_bypass, flash_clk_tick, periph_bus_tick;
	wire rtc_debug_freeze, indep_watchdog_debug_freeze;
	wire [4:0] jtag_pin_release;
	wire [28:0] slow_block_reset, slow_block_clk_en;
	wire [3:0] fast_block_reset, fast_block_clk_en;
	int errors = 0, checks_done = 0;
	logic [31:0] n0, n1, n2, n3;
	logic [11:0] ofs[11] = '{12'h008, 12'h014, 12'h01C, 12'h020, 12'h024, 12'h038,
		12'h040, 12'h050, 12'h060, 12'h070, 12'h080};
	logic [31:0] msk[11] = '{32'h3, 32'h1F, 32'h18, 32'h1FF, 32'h1FF, 32'hF,
		32'h1FFFFFFF, 32'hF, 32'h1FFFFFFF, 32'hF, 32'h041FC002};
	logic [31:0] mdl[11];
	system_control_registers #(.CHIP_ID(ID)) u_system_control_registers (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.por_event(por_event),
		.reset_source(reset_source),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.boot_pin_a(boot_pin_a),
		.boot_pin_b(boot_pin_b),
		.extlogic_reset_req(extlogic_reset_req),
		.system_reset_req(system_reset_req),
		.wfi_entered(wfi_entered),
		.enter_sleep(enter_sleep),
		.enter_stop(enter_stop),
		.enter_standby(enter_standby),
		.stop_wakeup(stop_wakeup),
		.pll_ready(pll_ready),
		.ext_osc_ready(ext_osc_ready),
		.pll_on(pll_on),
		.ext_osc_enable(ext_osc_enable),
		.ext_osc_bypass(ext_osc_bypass),
		.flash_clk_tick(flash_clk_tick),
		.periph_bus_tick(periph_bus_tick),
		.jtag_pin_release(jtag_pin_release),
		.debug_halted(debug_halted),
		.rtc_debug_freeze(rtc_debug_freeze),
		.indep_watchdog_debug_freeze(indep_watchdog_debug_freeze),
		.ext_irq_lines(ext_irq_lines),
		.rtc_alarm(rtc_alarm),
		.slow_block_reset(slow_block_reset),
		.fast_block_reset(fast_block_reset),
		.slow_block_clk_en(slow_block_clk_en),
		.fast_block_clk_en(fast_block_clk_en)
	);
	always #2 clk_sys = ~clk_sys;
	task final_report;
		if (errors == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_write <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk_sys);
		reg_write <= 0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_read <= 1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_read <= 0;
		#1;
		chk("rdata", e, reg_rdata);
	endtask
	// Counts are sampled 1 ns after each edge, so the launching edge has settled.
	task automatic cnt(input int c);
		n0 = 0;
		n1 = 0;
		n2 = 0;
		n3 = 0;
		repeat (c) begin
			#1;
			n0 += system_reset_req;
			n1 += flash_clk_tick;
			n2 += periph_bus_tick;
			n3 += stop_wakeup;
			@(posedge clk_sys);
		end
	endtask
	initial begin
		#40000;
		errors++;
		final_report();
	end
	initial begin
		por_event <= 1;
		d = $urandom(95465);
		repeat (3) @(posedge clk_sys);
		rst_n <= 1;
		por_event <= 0;
		repeat (3) @(posedge clk_sys);
		boot_pin_a <= 1;
		boot_pin_b <= 0;
		@(posedge clk_sys);
		boot_pin_a <= 0;
		boot_pin_b <= 1;
		rd(12'h000, 32'h1);
		rd(12'h004, 32'h08000000);
		@(posedge clk_sys);
		reset_source <= 5'h1E;
		@(posedge clk_sys);
		reset_source <= 0;
		wr(12'h014, 32'h1F);
		@(posedge clk_sys);
		rst_n <= 0;
		@(posedge clk_sys);
		rst_n <= 1;
		rd(12'h014, 32'h0);
		rd(12'h004, 32'hEC000000);
		rd(12'h000, 32'h2);
		wr(12'h004, 32'h1);
		cnt(20);
		chk("swrst_len", 15, n0);
		rd(12'h004, 32'hFC000000);
		wr(12'h004, 32'h01000000);
		rd(12'h004, 32'h0);
		extlogic_reset_req <= 1;
		cnt(8);
		chk("ext_off", 0, n0);
		rd(12'h004, 32'h0);
		wr(12'h004, 32'h2);
		cnt(8);
		chk("ext_on", 8, n0);
		extlogic_reset_req <= 0;
		rd(12'h004, 32'h02000002);
		for (int i = 0; i < 11; i++) begin
			mdl[i] = $urandom;
			wr(ofs[i], mdl[i]);
			rd(ofs[i], mdl[i] & msk[i]);
		end
		chk("jtag", mdl[1][4:0], jtag_pin_release);
		chk("srst", mdl[6][28:0], slow_block_reset);
		chk("frst", mdl[7][3:0], fast_block_reset);
		chk("sgate", mdl[8][28:0], slow_block_clk_en);
		chk("fgate", mdl[9][3:0], fast_block_clk_en);
		wr(12'h01C, 32'h18);
		wr(12'h080, 32'hFFFFFFFF);
		wr(12'h060, 32'hFFFFFFFF);
		debug_halted <= 1;
		@(posedge clk_sys);
		#1;
		chk("freeze", 2'h3, {rtc_debug_freeze, indep_watchdog_debug_freeze});
		chk("sfrz", 29'h1FFFFFFF & ~29'h041FC002, slow_block_clk_en);
		debug_halted <= 0;
		wr(12'h00C, 32'h112C);
		#1;
		chk("osc", 3'h7, {pll_on, ext_osc_enable, ext_osc_bypass});
		wr(12'h038, 32'h3);
		rd(12'h00C, 32'h116C);
		cnt(48);
		chk("fticks", 24, n1);
		chk("pticks", 12, n2);
		wfi_entered <= 1;
		for (int m = 0; m < 4; m++) begin
			wr(12'h008, m);
			#1;
			chk("lp", (m == 2) ? 0 : 1 << ((m == 3) ? 2 : m),
				{enter_standby, enter_stop, enter_sleep});
		end
		// A write while the clock enable is low must leave the register alone.
		clk_en <= 0;
		wr(12'h008, 32'h1);
		clk_en <= 1;
		rd(12'h008, 32'h3);
		wr(12'h020, 32'h101);
		wr(12'h024, 32'h2);
		ext_irq_lines <= 8'h02;
		cnt(8);
		chk("no_wake", 0, n3);
		ext_irq_lines <= 8'h01;
		rtc_alarm <= 1;
		cnt(8);
		chk("wake", 1, n3);
		rd(12'h028, 32'h103);
		wr(12'h028, 32'h1FF);
		rd(12'h028, 32'h0);
		wr(12'h100, d);
		rd(12'h100, ID);
		rd(12'h0FC, 32'h0);
		final_report();
	end
endmodule
